// >>> ckcfg_pkg.sv
// constants for the clock generator configuration register bank
// assumes a byte-wide register port driven by an smbus slave engine
package ckcfg_pkg;
    localparam logic [7:0] OFS_STOP_STATE = 8'h0b;
    localparam logic [7:0] OFS_PAIR01_Z = 8'h0c;
    localparam logic [7:0] OFS_PAIR23_Z = 8'h0d;
    localparam logic [7:0] OFS_GATE01_BIAS = 8'h0e;
    localparam logic [7:0] OFS_GATE23_BIAS = 8'h0f;
    localparam logic [7:0] OFS_POWER_BIAS = 8'h10;
    localparam logic [7:0] OFS_GATE_SENSE = 8'h12;
    localparam logic [7:0] OFS_POWER_SENSE = 8'h13;
    // field positions (low bit of each field)
    localparam int POS_STOP = 0;
    localparam int POS_Z_HI = 6;
    localparam int POS_Z_MID = 4;
    localparam int POS_Z_LO = 2;
    localparam int POS_PGOOD_BIAS = 0;
    localparam int POS_SENSE3 = 6;
    localparam int POS_SENSE2 = 5;
    localparam int POS_SENSE1 = 3;
    localparam int POS_SENSE0 = 1;
    localparam int POS_PD_SENSE = 0;
    // codes
    localparam logic [1:0] STOP_LOW_LOW = 2'h0;
    localparam logic [1:0] STOP_FLOAT = 2'h1;
    localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
    localparam logic [1:0] STOP_LOW_HIGH = 2'h3;
    localparam logic [1:0] ZSEL_33 = 2'h0;
    localparam logic [1:0] ZSEL_85 = 2'h1;
    localparam logic [1:0] ZSEL_100 = 2'h2;
    localparam logic [1:0] ZSEL_RESERVED = 2'h3;
    localparam logic [1:0] BIAS_NONE = 2'h0;
    localparam logic [1:0] BIAS_DOWN = 2'h1;
    localparam logic [1:0] BIAS_UP = 2'h2;
    localparam logic [1:0] BIAS_BOTH = 2'h3;
    // values after reset
    localparam logic [1:0] RST_STOP = STOP_LOW_LOW;
    localparam logic [1:0] RST_ZSEL = ZSEL_100;
    localparam logic [1:0] RST_GATE_BIAS = BIAS_DOWN;
    localparam logic [1:0] RST_PGOOD_BIAS = BIAS_UP;
    localparam logic [3:0] RST_GATE_SENSE = 4'h0;
    localparam logic RST_PD_SENSE = 1'b0;
    // reserved bits 7:2 of the power pin bias byte read as their defaults
    localparam logic [5:0] RSVD_POWER_BIAS = 6'h09;
endpackage

// >>> ckcfg_regs.sv
// configuration register bank and output-gate logic of a four-pair clock gen
// assumes the smbus engine and pll share clock_i; pins arrive asynchronously
`timescale 1ns/1ps
module ckcfg_regs (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic keep_cfg_in_sleep_i,
    input wire logic [3:0] pair_gate_pin_i,
    input wire logic power_good_down_pin_i,
    input wire logic pll_clk_i,
    input wire logic aux_clk_i,
    input wire logic aux_enable_i,
    output logic [3:0] clock_pair_out_true_o,
    output logic [3:0] clock_pair_out_comp_o,
    output logic [3:0] clock_pair_out_oe_o,
    output logic aux_out_o,
    output logic aux_oe_o,
    output logic [1:0] pair0_zsel_o,
    output logic [1:0] pair1_zsel_o,
    output logic [1:0] pair2_zsel_o,
    output logic [1:0] pair3_zsel_o,
    output logic [1:0] gate0_bias_sel_o,
    output logic [1:0] gate1_bias_sel_o,
    output logic [1:0] gate2_bias_sel_o,
    output logic [1:0] gate3_bias_sel_o,
    output logic [1:0] pgood_pin_bias_sel_o,
    output logic power_down_o
);
    import ckcfg_pkg::*;

    logic [1:0] disable_level_sel, next_disable_level_sel;
    logic [1:0] zsel [4];
    logic [1:0] next_zsel [4];
    logic [1:0] bias [4];
    logic [1:0] next_bias [4];
    logic [1:0] pgood_bias, next_pgood_bias;
    logic [3:0] gate_sense, next_gate_sense;
    logic pd_sense, next_pd_sense;
    logic [7:0] rdata, next_rdata;
    logic [3:0] gate_meta, gate_sync;
    logic pd_meta, pd_sync;
    logic [3:0] pair_run, next_pair_run;
    logic [3:0] run_req;
    logic pd_active;
    logic wipe;
    logic [2:0] stop_levels;

    // two-flop synchronisers for the pins
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gate_meta <= 4'h0;
            gate_sync <= 4'h0;
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
        end else begin
            gate_meta <= pair_gate_pin_i;
            gate_sync <= gate_meta;
            pd_meta <= power_good_down_pin_i;
            pd_sync <= pd_meta;
        end
    end

    assign pd_active = (pd_sync == pd_sense);
    assign wipe = pd_active && !keep_cfg_in_sleep_i;
    assign power_down_o = pd_active;

    // keeps old code when the reserved impedance is written
    function automatic logic [1:0] zpick(logic [1:0] old, logic [1:0] nw);
        zpick = (nw == ZSEL_RESERVED) ? old : nw;
    endfunction

    always_comb begin
        next_disable_level_sel = disable_level_sel;
        next_zsel = zsel;
        next_bias = bias;
        next_pgood_bias = pgood_bias;
        next_gate_sense = gate_sense;
        next_pd_sense = pd_sense;
        if (wipe) begin
            // defaults win over a write landing during power-down while keep_cfg_in_sleep_i is low
            next_disable_level_sel = RST_STOP;
            for (int i = 0; i < 4; i++) begin
                next_zsel[i] = RST_ZSEL;
                next_bias[i] = RST_GATE_BIAS;
            end
            next_pgood_bias = RST_PGOOD_BIAS;
            next_gate_sense = RST_GATE_SENSE;
            next_pd_sense = RST_PD_SENSE;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFS_STOP_STATE:
                    next_disable_level_sel = reg_wdata_i[POS_STOP +: 2];
                OFS_PAIR01_Z: begin
                    next_zsel[1] = zpick(zsel[1], reg_wdata_i[POS_Z_HI +: 2]);
                    next_zsel[0] = zpick(zsel[0], reg_wdata_i[POS_Z_LO +: 2]);
                end
                OFS_PAIR23_Z: begin
                    next_zsel[3] = zpick(zsel[3], reg_wdata_i[POS_Z_MID +: 2]);
                    next_zsel[2] = zpick(zsel[2], reg_wdata_i[POS_Z_LO +: 2]);
                end
                OFS_GATE01_BIAS: begin
                    next_bias[1] = reg_wdata_i[POS_Z_HI +: 2];
                    next_bias[0] = reg_wdata_i[POS_Z_LO +: 2];
                end
                OFS_GATE23_BIAS: begin
                    next_bias[3] = reg_wdata_i[POS_Z_MID +: 2];
                    next_bias[2] = reg_wdata_i[POS_Z_LO +: 2];
                end
                OFS_POWER_BIAS:
                    next_pgood_bias = reg_wdata_i[POS_PGOOD_BIAS +: 2];
                OFS_GATE_SENSE: begin
                    next_gate_sense[3] = reg_wdata_i[POS_SENSE3];
                    next_gate_sense[2] = reg_wdata_i[POS_SENSE2];
                    next_gate_sense[1] = reg_wdata_i[POS_SENSE1];
                    next_gate_sense[0] = reg_wdata_i[POS_SENSE0];
                end
                OFS_POWER_SENSE:
                    next_pd_sense = reg_wdata_i[POS_PD_SENSE];
                default: ;
            endcase
        end
    end

    // read data, one cycle after the address; reserved bits read zero, except power pin bias bits 7:2, which read RSVD_POWER_BIAS
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr_i)
            OFS_STOP_STATE: next_rdata[POS_STOP +: 2] = disable_level_sel;
            OFS_PAIR01_Z: begin
                next_rdata[POS_Z_HI +: 2] = zsel[1];
                next_rdata[POS_Z_LO +: 2] = zsel[0];
            end
            OFS_PAIR23_Z: begin
                next_rdata[POS_Z_MID +: 2] = zsel[3];
                next_rdata[POS_Z_LO +: 2] = zsel[2];
            end
            OFS_GATE01_BIAS: begin
                next_rdata[POS_Z_HI +: 2] = bias[1];
                next_rdata[POS_Z_LO +: 2] = bias[0];
            end
            OFS_GATE23_BIAS: begin
                next_rdata[POS_Z_MID +: 2] = bias[3];
                next_rdata[POS_Z_LO +: 2] = bias[2];
            end
            OFS_POWER_BIAS:
                next_rdata = {RSVD_POWER_BIAS, pgood_bias};
            OFS_GATE_SENSE: begin
                next_rdata[POS_SENSE3] = gate_sense[3];
                next_rdata[POS_SENSE2] = gate_sense[2];
                next_rdata[POS_SENSE1] = gate_sense[1];
                next_rdata[POS_SENSE0] = gate_sense[0];
            end
            OFS_POWER_SENSE: next_rdata[POS_PD_SENSE] = pd_sense;
            default: ;
        endcase
    end

    // pair gating: the run state moves only while the pll clock is low,
    // so neither a runt high pulse nor a truncated one reaches the pair
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            run_req[i] = (gate_sync[i] == gate_sense[i]) && !pd_active;
        end
        next_pair_run = pll_clk_i ? pair_run : run_req;
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            disable_level_sel <= RST_STOP;
            for (int i = 0; i < 4; i++) begin
                zsel[i] <= RST_ZSEL;
                bias[i] <= RST_GATE_BIAS;
            end
            pgood_bias <= RST_PGOOD_BIAS;
            gate_sense <= RST_GATE_SENSE;
            pd_sense <= RST_PD_SENSE;
            rdata <= 8'h00;
            pair_run <= 4'h0;
        end else begin
            disable_level_sel <= next_disable_level_sel;
            zsel <= next_zsel;
            bias <= next_bias;
            pgood_bias <= next_pgood_bias;
            gate_sense <= next_gate_sense;
            pd_sense <= next_pd_sense;
            rdata <= next_rdata;
            pair_run <= next_pair_run;
        end
    end

    // stop levels: true, complement, drive enable
    function automatic logic [2:0] stop_lv(logic [1:0] code);
        unique case (code)
            STOP_LOW_LOW: stop_lv = 3'b001;
            STOP_FLOAT: stop_lv = 3'b000;
            STOP_HIGH_LOW: stop_lv = 3'b101;
            STOP_LOW_HIGH: stop_lv = 3'b011;
        endcase
    endfunction

    assign stop_levels = stop_lv(disable_level_sel);

    // the clock itself passes without a flop, so pair outputs follow pll_clk_i and aux_out_o follows aux_clk_i
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pair_run[i]) begin
                clock_pair_out_true_o[i] = pll_clk_i;
                clock_pair_out_comp_o[i] = !pll_clk_i;
                clock_pair_out_oe_o[i] = 1'b1;
            end else begin
                {clock_pair_out_true_o[i], clock_pair_out_comp_o[i],
                    clock_pair_out_oe_o[i]} = stop_levels;
            end
        end
        if (aux_enable_i) begin
            aux_out_o = aux_clk_i;
            aux_oe_o = 1'b1;
        end else begin
            // single-ended aux rests at the complement level: 10 low, 11 high
            aux_out_o = stop_levels[1];
            aux_oe_o = stop_levels[0];
        end
    end

    assign reg_rdata_o = rdata;
    assign pair0_zsel_o = zsel[0];
    assign pair1_zsel_o = zsel[1];
    assign pair2_zsel_o = zsel[2];
    assign pair3_zsel_o = zsel[3];
    assign gate0_bias_sel_o = bias[0];
    assign gate1_bias_sel_o = bias[1];
    assign gate2_bias_sel_o = bias[2];
    assign gate3_bias_sel_o = bias[3];
    assign pgood_pin_bias_sel_o = pgood_bias;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence wr_seq(logic [7:0] a);
        reg_wr_i && reg_addr_i == a && !wipe;
    endsequence

    chk_stop_float: assert property (
        !pair_run[0] && disable_level_sel == STOP_FLOAT
            |-> !clock_pair_out_oe_o[0])
        else $error("floating stop state still drives pair 0");
    chk_zsel_reserved: assert property (
        wr_seq(OFS_PAIR01_Z) ##0 reg_wdata_i[7:6] == ZSEL_RESERVED
            |=> pair1_zsel_o == $past(pair1_zsel_o))
        else $error("reserved impedance code changed pair 1");
    chk_pair1_zsel: assert property (
        wr_seq(OFS_PAIR01_Z) ##0 reg_wdata_i[7:6] != ZSEL_RESERVED
            |=> pair1_zsel_o == $past(reg_wdata_i[7:6]))
        else $error("pair 1 impedance not written");
    chk_pair3_zsel: assert property (
        wr_seq(OFS_PAIR23_Z) ##0 reg_wdata_i[5:4] != ZSEL_RESERVED
            |=> pair3_zsel_o == $past(reg_wdata_i[5:4]))
        else $error("pair 3 impedance not written");
    chk_gate_bias: assert property (
        wr_seq(OFS_GATE23_BIAS) |=> gate2_bias_sel_o == $past(reg_wdata_i[3:2]))
        else $error("gate 2 bias not written");
    chk_power_bias_rd: assert property (
        reg_addr_i == OFS_POWER_BIAS |=> reg_rdata_o[1:0] == $past(pgood_bias)
            && reg_rdata_o[7:2] == RSVD_POWER_BIAS)
        else $error("power pin bias read wrong");
    chk_sense_wr: assert property (
        wr_seq(OFS_GATE_SENSE) |=> gate_sense[3] == $past(reg_wdata_i[6])
            && gate_sense[0] == $past(reg_wdata_i[1]))
        else $error("gate sense bits misplaced");
    chk_gate_enable: assert property (
        $rose(pair_run[0]) |-> $past(gate_sync[0] == gate_sense[0] && !pd_active))
        else $error("pair 0 started without its gate");
    chk_pd_sense: assert property (
        pd_sync == pd_sense |-> power_down_o ##1 pair_run == 4'h0
            || $past(pll_clk_i))
        else $error("power-down sense not honoured");
    chk_aux_stop: assert property (
        !aux_enable_i && disable_level_sel == STOP_LOW_HIGH
            |-> aux_oe_o && aux_out_o)
        else $error("aux output ignores stop state");
    chk_sleep_clear: assert property (
        wipe |=> gate_sense == RST_GATE_SENSE && pgood_bias == RST_PGOOD_BIAS)
        else $error("config not cleared in power-down");
    chk_clean_switch: assert property (
        pair_run != $past(pair_run) |-> $past(!pll_clk_i))
        else $error("pair switched while clock high");
endmodule

// >>> ckcfg_host.sv
// smbus-side host model: byte writes and registered reads of the bank
// assumes one clock shared with the bank; drives 1 ns after each rising edge
`timescale 1ns/1ps
module ckcfg_host (
    input wire logic clock_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // data is inverted once the strobe drops so stale bytes cannot match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        reg_addr_o = a;
        reg_wr_o = 1'b1;
        reg_wdata_o = d;
        @(posedge clock_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        #1;
        reg_addr_o = a;
        @(posedge clock_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule

// >>> clock_gen_pin_config_regs_tb.sv
// self-checking bench for the clock generator configuration bank
// assumes ckcfg_pkg is compiled first; ckcfg_host stands as smbus engine
`timescale 1ns/1ps
module clock_gen_pin_config_regs_tb;
    import ckcfg_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic keep = 1'b1;
    logic [3:0] gate_pin = 4'hf;
    logic pwr_pin = 1'b1;
    logic pll_clk = 1'b0;
    logic aux_en = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, aux_out, aux_oe, pdown;
    logic [3:0] pt, pc, poe;
    logic [1:0] z0, z1, z2, z3, b0, b1, b2, b3, bp;
    logic [7:0] sh [0:31];
    logic [7:0] adr [0:8] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10,
        8'h11, 8'h12, 8'h13};
    logic [15:0] cw [0:5] = '{16'h0c40, 16'h0cff, 16'h0dff, 16'h10ff,
        16'h11ff, 16'h13fe};
    int fail_count = 0;
    int n_tests = 0;
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) #1 pll_clk = ~pll_clk;
    ckcfg_host u_host (.clock_i(clock_i), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata));
    ckcfg_regs u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .keep_cfg_in_sleep_i(keep),
        .pair_gate_pin_i(gate_pin), .power_good_down_pin_i(pwr_pin),
        .pll_clk_i(pll_clk), .aux_clk_i(pll_clk), .aux_enable_i(aux_en),
        .clock_pair_out_true_o(pt), .clock_pair_out_comp_o(pc),
        .clock_pair_out_oe_o(poe), .aux_out_o(aux_out), .aux_oe_o(aux_oe),
        .pair0_zsel_o(z0), .pair1_zsel_o(z1), .pair2_zsel_o(z2),
        .pair3_zsel_o(z3), .gate0_bias_sel_o(b0), .gate1_bias_sel_o(b1),
        .gate2_bias_sel_o(b2), .gate3_bias_sel_o(b3),
        .pgood_pin_bias_sel_o(bp), .power_down_o(pdown));
    task automatic chk(input string name, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic dflt();
        foreach (sh[i]) sh[i] = 8'h00;
        sh[12] = 8'h88;
        sh[13] = 8'h28;
        sh[14] = 8'h44;
        sh[15] = 8'h14;
        sh[16] = 8'h26;
    endtask
    // reserved impedance code leaves the old field in place
    function automatic logic [1:0] zf(logic [1:0] w, o);
        return (w == ZSEL_RESERVED) ? o : w;
    endfunction
    function automatic logic [7:0] nxt(logic [7:0] a, w, o);
        case (a)
            8'h0b: return w & 8'h03;
            8'h0c: return {zf(w[7:6], o[7:6]), 2'b00, zf(w[3:2], o[3:2]),
                2'b00};
            8'h0d: return {2'b00, zf(w[5:4], o[5:4]), zf(w[3:2], o[3:2]),
                2'b00};
            8'h0e: return w & 8'hcc;
            8'h0f: return w & 8'h3c;
            8'h10: return {6'h09, w[1:0]};
            8'h12: return w & 8'h6a;
            8'h13: return w & 8'h01;
            default: return 8'h00;
        endcase
    endfunction
    task automatic ports_chk();
        chk("zsel01", {4'h0, z1, z0},
            {4'h0, sh[12][7:6], sh[12][3:2]});
        chk("zsel23", {4'h0, z3, z2}, {4'h0, sh[13][5:2]});
        chk("bias01", {4'h0, b1, b0},
            {4'h0, sh[14][7:6], sh[14][3:2]});
        chk("bias23", {4'h0, b3, b2}, {4'h0, sh[15][5:2]});
        chk("bias pwr", {6'h00, bp}, {6'h00, sh[16][1:0]});
    endtask
    task automatic rd_all();
        logic [7:0] r;
        for (int i = 0; i < 9; i++) begin
            u_host.rd(adr[i], r);
            chk("register", r, sh[adr[i][4:0]]);
        end
    endtask
    task automatic wr_chk(input logic [7:0] a, d);
        logic [7:0] r;
        u_host.wr(a, d);
        sh[a[4:0]] = nxt(a, d, sh[a[4:0]]);
        u_host.rd(a, r);
        chk("readback", r, sh[a[4:0]]);
        ports_chk();
    endtask
    task automatic pair_chk(input logic [3:0] p);
        logic [1:0] st;
        logic [3:0] run;
        logic [2:0] e;
        st = sh[11][1:0];
        run = ~(p ^ {sh[18][6], sh[18][5], sh[18][3], sh[18][1]});
        for (int i = 0; i < 4; i++) begin
            e = run[i] ? {1'b1, pll_clk, ~pll_clk} : {st != STOP_FLOAT,
                st == STOP_HIGH_LOW, st == STOP_LOW_HIGH};
            chk("pair", {5'h00, poe[i], pt[i] & poe[i], pc[i] & poe[i]},
                {5'h00, e});
        end
        if (!aux_en) begin
            chk("aux", {6'h00, aux_oe, aux_out & aux_oe}, {6'h00,
                st != STOP_FLOAT, st == STOP_LOW_HIGH});
        end else begin
            chk("aux run", {6'h00, aux_oe, aux_out},
                {6'h00, 1'b1, pll_clk});
        end
    endtask
    task automatic pwr_step(input logic lvl, input logic exp);
        pwr_pin = lvl;
        repeat (4) @(posedge clock_i);
        #1;
        chk("power down", {7'h00, pdown}, {7'h00, exp});
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 6000);
        fail_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'h0000_fc01));
        repeat (6) @(posedge clock_i);
        #1;
        nrst_i = 1'b1;
        dflt();
        rd_all();
        ports_chk();
        $display("test reset values done");
        foreach (cw[i]) wr_chk(cw[i][15:8], cw[i][7:0]);
        repeat (40) wr_chk(adr[$urandom_range(0, 8)], 8'($urandom));
        wr_chk(8'h13, 8'h00);
        $display("test register access done");
        // every stop code twice, with random pin levels and senses
        for (int k = 0; k < 8; k++) begin
            wr_chk(8'h0b, 8'(k % 4));
            wr_chk(8'h12, 8'($urandom));
            gate_pin = 4'($urandom);
            aux_en = 1'($urandom);
            repeat (8) @(posedge clock_i);
            @(negedge clock_i);
            pair_chk(gate_pin);
        end
        $display("test output gating done");
        @(posedge clock_i);
        #1;
        keep = 1'b0;
        wr_chk(8'h0b, 8'h03);
        pwr_step(1'b0, 1'b1);
        pwr_step(1'b1, 1'b0);
        dflt();
        rd_all();
        keep = 1'b1;
        wr_chk(8'h0b, 8'h02);
        wr_chk(8'h13, 8'h01);
        pwr_step(1'b1, 1'b1);
        pwr_step(1'b0, 1'b0);
        rd_all();
        $display("test power down done");
        test_done();
    end
endmodule
